//--- include/amr_pkg.sv
// Package for the model-specific register bank: indices, fields, types
package amr_pkg;
    localparam int AMR_DATA_W = 64;
    localparam int AMR_IDX_W = 32;
    // Register indices
    localparam logic [31:0] AMR_IDX_MC_ADDR = 32'h0000_0000;
    localparam logic [31:0] AMR_IDX_MC_TYPE = 32'h0000_0001;
    localparam logic [31:0] AMR_IDX_MON_FILT = 32'h0000_0006;
    localparam logic [31:0] AMR_IDX_TSTAMP = 32'h0000_0010;
    localparam logic [31:0] AMR_IDX_PLAT_ID = 32'h0000_0017;
    localparam logic [31:0] AMR_IDX_INTC_BASE = 32'h0000_001B;
    // Platform id field
    localparam int AMR_PLAT_LSB = 50;
    localparam int AMR_PLAT_MSB = 52;
    // Interrupt controller base fields
    localparam int AMR_INTC_BOOT_BIT = 8;
    localparam int AMR_INTC_EN_BIT = 11;
    localparam int AMR_INTC_BASE_LSB = 12;
    // Default maximum physical address width
    localparam int AMR_PHYS_W_DEF = 36;
    localparam logic [63:0] AMR_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [63:0] AMR_INTC_RESET = 64'h0000_0000_FEE0_0000;

    // Access request from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [AMR_IDX_W-1:0] idx;
        logic [AMR_DATA_W-1:0] wdata;
    } amr_req_type;

    // Answer to the core
    typedef struct packed {
        logic done;
        logic fault;
        logic [AMR_DATA_W-1:0] rdata;
    } amr_rsp_type;
endpackage : amr_pkg

//--- src/amr_idx_decode.sv
// Index decoder for the model-specific register bank
`timescale 1ns/100ps
`default_nettype none
module amr_idx_decode
    import amr_pkg::*;
(
    input wire logic [AMR_IDX_W-1:0] idx_i,
    output logic [5:0] sel_o,
    output logic hit_o
);
    // One-hot select; a miss means the index is not implemented
    always_comb begin
        sel_o = 6'h00;
        case (idx_i)
            AMR_IDX_MC_ADDR: sel_o = 6'h01;
            AMR_IDX_MC_TYPE: sel_o = 6'h02;
            AMR_IDX_MON_FILT: sel_o = 6'h04;
            AMR_IDX_TSTAMP: sel_o = 6'h08;
            AMR_IDX_PLAT_ID: sel_o = 6'h10;
            AMR_IDX_INTC_BASE: sel_o = 6'h20;
            default: sel_o = 6'h00;
        endcase
        hit_o = |sel_o;
    end
endmodule : amr_idx_decode
`default_nettype wire

//--- src/amr_bank.sv
// Model-specific register bank reached by read and write register instructions
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Every register reads by its numeric index through the core port; only filter, timestamp and base take writes.
// - An unimplemented index raises a fault; the access still completes, with done set and zero data.
// - Indices outside the architectural set are model-specific and decode as faults.
// - Platform id is a read-only 3-bit code at bits 52:50.
// - Base register bit 11 is a writable enable; bit 8 flags the boot core.
// - Address field width follows the maximum physical address width parameter.
module amr_bank
    import amr_pkg::*;
#(
    parameter int PHYS_W = AMR_PHYS_W_DEF
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire amr_req_type req_i,
    input wire logic [2:0] plat_code_i,
    input wire logic boot_core_i,
    input wire logic [63:0] mc_addr_i,
    input wire logic [63:0] mc_type_i,
    output amr_rsp_type rsp_o,
    output logic intc_en_o,
    output logic [PHYS_W-AMR_INTC_BASE_LSB-1:0] intc_base_o,
    output logic [63:0] tstamp_o
);
    // Writable mask of the base register, sized by the physical width
    localparam logic [63:0] INTC_WMASK =
        (((64'h1 << PHYS_W) - 64'h1) & ~((64'h1 << AMR_INTC_BASE_LSB) - 64'h1))
        | (64'h1 << AMR_INTC_EN_BIT);

    logic [5:0] sel;
    logic hit;
    logic [63:0] mon_filt_reg;
    logic [63:0] tstamp_reg;
    logic [63:0] intc_reg;
    logic [2:0] plat_reg;
    logic boot_reg;
    logic strap_done_reg;
    // Strap synchronisers, first and second stage
    logic [2:0] plat_meta_reg;
    logic [2:0] plat_sync_reg;
    logic boot_meta_reg;
    logic boot_sync_reg;
    logic [63:0] rd_mux;
    logic acc;

    amr_idx_decode u_dec (
        .idx_i(req_i.idx),
        .sel_o(sel),
        .hit_o(hit)
    );

    assign acc = req_i.rd | req_i.wr;

    // Straps are pins: two flops settle them before the capture below reads them
    // No reset here, so the value is already settled when reset ends
    always_ff @(posedge mclk_i) begin
        plat_meta_reg <= plat_code_i;
        plat_sync_reg <= plat_meta_reg;
        boot_meta_reg <= boot_core_i;
        boot_sync_reg <= boot_meta_reg;
    end

    // Straps caught once after reset release, so reset loads only constants
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            strap_done_reg <= 1'b0;
            plat_reg <= 3'h0;
            boot_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            plat_reg <= plat_sync_reg;
            boot_reg <= boot_sync_reg;
        end
    end

    // Monitor filter size, plain read-write
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mon_filt_reg <= AMR_ZERO;
        end else if (req_i.wr && sel[2]) begin
            mon_filt_reg <= req_i.wdata;
        end
    end

    // Cycle timestamp counts every clock; a write loads it
    // A write wins over counting in its cycle; counting resumes next clock, so a later read shows the load plus elapsed cycles
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tstamp_reg <= AMR_ZERO;
        end else if (req_i.wr && sel[3]) begin
            tstamp_reg <= req_i.wdata;
        end else begin
            tstamp_reg <= tstamp_reg + 64'h1;
        end
    end

    // Base register keeps only its writable bits
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            intc_reg <= AMR_INTC_RESET & INTC_WMASK;
        end else if (req_i.wr && sel[5]) begin
            intc_reg <= req_i.wdata & INTC_WMASK;
        end
    end

    // Read data assembly; reserved bits stay zero
    // Unused select codes fall to zero, which also covers faulted reads
    always_comb begin
        rd_mux = AMR_ZERO;
        case (sel)
            6'h01: rd_mux = mc_addr_i;
            6'h02: rd_mux = mc_type_i;
            6'h04: rd_mux = mon_filt_reg;
            6'h08: rd_mux = tstamp_reg;
            6'h10: rd_mux[AMR_PLAT_MSB:AMR_PLAT_LSB] = plat_reg;
            6'h20: begin
                rd_mux = intc_reg;
                rd_mux[AMR_INTC_BOOT_BIT] = boot_reg;
            end
            default: rd_mux = AMR_ZERO;
        endcase
    end

    // Answer one cycle after the request; faults carry zero data
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.done <= acc;
            rsp_o.fault <= acc && !hit;
            rsp_o.rdata <= (req_i.rd && hit) ? rd_mux : AMR_ZERO;
        end
    end

    // Side outputs registered from state
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            intc_en_o <= 1'b0;
            intc_base_o <= '0;
            tstamp_o <= AMR_ZERO;
        end else begin
            intc_en_o <= intc_reg[AMR_INTC_EN_BIT];
            intc_base_o <= intc_reg[PHYS_W-1:AMR_INTC_BASE_LSB];
            tstamp_o <= tstamp_reg;
        end
    end

    // Answer checks: one answer per access, on the next edge, faults carry no data
    a_fault_unmapped: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (acc && !hit) |=> (rsp_o.done && rsp_o.fault))
        else $error("unmapped index did not fault");
    a_hit_no_fault: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (acc && hit) |=> (rsp_o.done && !rsp_o.fault))
        else $error("mapped index faulted");
    a_done_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !acc |=> !rsp_o.done)
        else $error("answer without an access");
    a_fault_data: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rsp_o.fault |-> (rsp_o.rdata == AMR_ZERO))
        else $error("faulted access returned data");
    a_fault_no_state: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.wr && !hit) |=> ($stable(mon_filt_reg) && $stable(intc_reg)))
        else $error("faulted write changed state");
    a_wr_no_data: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.wr && !req_i.rd) |=> (rsp_o.rdata == AMR_ZERO))
        else $error("write answered with data");

    // Register content checks; bit positions come from the package, not from here
    a_mon_roundtrip: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.wr && req_i.idx == AMR_IDX_MON_FILT) |=> (mon_filt_reg == $past(req_i.wdata)))
        else $error("filter size write lost");
    a_filt_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(req_i.wr && sel[2]) |=> $stable(mon_filt_reg))
        else $error("filter size changed without a write");
    a_mca_live: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.rd && req_i.idx == AMR_IDX_MC_ADDR) |=> (rsp_o.rdata == $past(mc_addr_i)))
        else $error("machine check address read wrong");
    a_strap_capture: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(strap_done_reg) |-> (plat_reg == $past(plat_sync_reg)))
        else $error("platform code not captured");
    a_plat_layout: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.rd && req_i.idx == AMR_IDX_PLAT_ID) |=>
        (rsp_o.rdata == (64'($past(plat_reg)) << AMR_PLAT_LSB)))
        else $error("platform id layout wrong");
    a_plat_ro: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        strap_done_reg |=> $stable(plat_reg))
        else $error("platform id changed");
    a_en_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.wr && req_i.idx == AMR_IDX_INTC_BASE) |-> ##2
        (intc_en_o == $past(req_i.wdata[AMR_INTC_EN_BIT], 2)))
        else $error("enable bit not written");
    a_intc_resv: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (intc_reg & ~INTC_WMASK) == AMR_ZERO)
        else $error("base reserved bits set");
    a_intc_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.rd && req_i.idx == AMR_IDX_INTC_BASE) |=>
        ((rsp_o.rdata & ~(INTC_WMASK | (64'h1 << AMR_INTC_BOOT_BIT))) == AMR_ZERO))
        else $error("base read shows reserved bits");
    a_boot_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i.rd && req_i.idx == AMR_IDX_INTC_BASE) |=>
        (rsp_o.rdata[AMR_INTC_BOOT_BIT] == $past(boot_reg)))
        else $error("boot flag read wrong");
    a_tstamp_count: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(req_i.wr && sel[3]) |=> (tstamp_reg == $past(tstamp_reg) + 64'h1))
        else $error("timestamp did not count");
    a_ts_mirror: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        1'b1 |=> (tstamp_o == $past(tstamp_reg)))
        else $error("timestamp output lags wrongly");

    // Scenario coverage
    c_read_ok: cover property (@(posedge mclk_i) req_i.rd && hit ##1 rsp_o.done);
    c_fault: cover property (@(posedge mclk_i) acc && !hit ##1 rsp_o.fault);
    c_en_set: cover property (@(posedge mclk_i) $rose(intc_en_o));
    c_ts_load: cover property (@(posedge mclk_i) req_i.wr && sel[3] ##1 rsp_o.done);
    c_plat_read: cover property (@(posedge mclk_i) req_i.rd && sel[4] ##1 rsp_o.done);
endmodule : amr_bank
`default_nettype wire

//--- verif/amr_core_model.sv
// Behavioural processor core issuing register read and write instructions
`timescale 1ns/100ps
`default_nettype none
module amr_core_model
    import amr_pkg::*;
(
    input wire logic mclk_i,
    input wire amr_rsp_type rsp_i,
    output amr_req_type req_o
);
    // Family and model signature, value arbitrary; no instruction issues without it
    localparam logic [15:0] SIG_EXPECTED = 16'h0A5C;
    logic [15:0] sig_seen = 16'h0A5C;
    initial req_o = '0;
    // One instruction per call, entered at a falling edge, taken at the next rising edge
    task automatic access(input logic rd, input logic wr, input logic [31:0] idx,
            input logic [63:0] wd, output amr_rsp_type rsp);
        if (sig_seen === SIG_EXPECTED) begin
            req_o <= '{rd, wr, idx, wd};
        end
        @(negedge mclk_i);
        // The answer stands only in the cycle after the taking edge, so read it here
        rsp = rsp_i;
        // Released fields show the inverse so stale values never look valid
        req_o <= '{1'b0, 1'b0, ~idx, ~wd};
        @(negedge mclk_i);
    endtask : access
endmodule : amr_core_model
`default_nettype wire

//--- verif/architectural_model_register_file_tb.sv
// Self-checking bench for the model-specific register bank
`timescale 1ns/100ps
`default_nettype none
module architectural_model_register_file_tb
    import amr_pkg::*;
();
    localparam int PW = 36;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [63:0] mc_addr_i = 64'h0123_4567_89AB_CDEF;
    logic [63:0] mc_type_i = 64'h0000_0000_0000_0019;
    amr_req_type req;
    amr_rsp_type rsp_o;
    amr_rsp_type rsp;
    logic intc_en_o;
    logic [PW-13:0] intc_base_o;
    logic [63:0] tstamp_o;
    int failures = 0;
    int samples_checked = 0;
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    amr_core_model core (.mclk_i(mclk_i), .rsp_i(rsp_o), .req_o(req));
    amr_bank #(.PHYS_W(PW)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req),
        .plat_code_i(3'h5), .boot_core_i(1'b1), .mc_addr_i(mc_addr_i),
        .mc_type_i(mc_type_i), .rsp_o(rsp_o), .intc_en_o(intc_en_o),
        .intc_base_o(intc_base_o), .tstamp_o(tstamp_o));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // One instruction with its whole answer judged; writes answer zero data
    task automatic acc(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
            input logic flt, input logic [63:0] exp, input string what);
        core.access(~wr, wr, idx, wd, rsp);
        check({what, " done"}, {63'h0, rsp.done}, 64'h1);
        check({what, " fault"}, {63'h0, rsp.fault}, {63'h0, flt});
        check(what, rsp.rdata, exp);
    endtask : acc
    task automatic test_read_only();
        acc(1'b0, AMR_IDX_PLAT_ID, '0, 1'b0, 64'(3'h5) << AMR_PLAT_LSB, "plat");
        acc(1'b1, AMR_IDX_PLAT_ID, '1, 1'b0, '0, "plat wr");
        acc(1'b0, AMR_IDX_PLAT_ID, '0, 1'b0, 64'h0014_0000_0000_0000, "plat2");
        mc_addr_i = 64'hFEDC_BA98_7654_3210;
        acc(1'b1, AMR_IDX_MC_ADDR, '0, 1'b0, '0, "mca wr");
        acc(1'b0, AMR_IDX_MC_ADDR, '0, 1'b0, 64'hFEDC_BA98_7654_3210, "mca");
        acc(1'b0, AMR_IDX_MC_TYPE, '0, 1'b0, 64'h19, "mct");
    endtask : test_read_only
    task automatic test_intc_and_filter();
        acc(1'b0, AMR_IDX_INTC_BASE, '0, 1'b0, 64'h0000_0000_FEE0_0100, "intc rst");
        acc(1'b1, AMR_IDX_INTC_BASE, '1, 1'b0, '0, "intc wr");
        check("intc_en_o", {63'h0, intc_en_o}, 64'h1);
        check("intc_base_o", 64'(intc_base_o), 64'h0000_0000_00FF_FFFF);
        acc(1'b0, AMR_IDX_INTC_BASE, '0, 1'b0, 64'h0000_000F_FFFF_F900, "intc");
        acc(1'b0, AMR_IDX_MON_FILT, '0, 1'b0, '0, "filt rst");
        acc(1'b1, AMR_IDX_MON_FILT, 64'hA5A5_0000_5A5A_0040, 1'b0, '0, "filt wr");
        acc(1'b0, AMR_IDX_MON_FILT, '0, 1'b0, 64'hA5A5_0000_5A5A_0040, "filt");
    endtask : test_intc_and_filter
    // Load just below a 32-bit carry; one count shows on the read, two on the mirror
    task automatic test_timestamp();
        acc(1'b1, AMR_IDX_TSTAMP, 64'h0000_0000_FFFF_FFFF, 1'b0, '0, "ts wr");
        acc(1'b0, AMR_IDX_TSTAMP, '0, 1'b0, 64'h0000_0001_0000_0000, "ts");
        check("tstamp_o", tstamp_o, 64'h0000_0001_0000_0001);
    endtask : test_timestamp
    task automatic test_unmapped();
        logic [31:0] bad[4] = '{32'h2, 32'h1C, 32'h3A, 32'hFFFF_FFFF};
        foreach (bad[i]) begin
            acc(1'b0, bad[i], '0, 1'b1, '0, "bad rd");
            acc(1'b1, bad[i], '1, 1'b1, '0, "bad wr");
        end
    endtask : test_unmapped
    task automatic give_verdict();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // Watchdog sized well past the few dozen instructions of the run
    initial begin
        #10000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (5) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        test_read_only();
        test_intc_and_filter();
        test_timestamp();
        test_unmapped();
        give_verdict();
    end
endmodule : architectural_model_register_file_tb
`default_nettype wire
